/* hw/spptc_cmd_check.sv */
`default_nettype none
module spptc_cmd_check (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Command and status wrapper fields
  spptc_cmd_if.chk cmd
);
  import spptc_pkg::*;

  typedef struct packed {
    logic csw_valid;
    logic len_ok;
    logic [WORD_W-1:0] residue;
    logic [WORD_W-1:0] tag;
  } spptc_chk_state_t;

  spptc_chk_state_t s;
  spptc_chk_state_t next_s;

  // ----------------------------------------
  // Status wrapper fields for firmware
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.csw_valid = cmd.cbw_valid;
    if (cmd.cbw_valid) begin
      next_s.len_ok = (cmd.cbw_len >= CMD_LEN_MIN) && (cmd.cbw_len <= CMD_LEN_MAX);
      next_s.residue = cmd.expected - cmd.processed;
      next_s.tag = cmd.cbw_tag;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cmd.csw_valid = s.csw_valid;
  assign cmd.len_ok = s.len_ok;
  assign cmd.residue = s.residue;
  assign cmd.csw_tag = s.tag;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_len_range: assert property (cmd.cbw_valid |=> cmd.csw_valid &&
      cmd.len_ok == ($past(cmd.cbw_len) != 5'h00 && $past(cmd.cbw_len) < 5'h11))
    else $error("command length check wrong");
  a_residue_value: assert property (cmd.cbw_valid |=>
      cmd.residue == $past(cmd.expected) - $past(cmd.processed))
    else $error("residue wrong");
  a_tag_echo: assert property (cmd.cbw_valid |=> cmd.csw_tag == $past(cmd.cbw_tag))
    else $error("tag not echoed");
endmodule
`default_nettype wire

/* hw/spptc_cmd_if.sv */
`default_nettype none
interface spptc_cmd_if;
  import spptc_pkg::*;
  logic cbw_valid;
  logic [LEN_W-1:0] cbw_len;
  logic [WORD_W-1:0] cbw_tag;
  logic [WORD_W-1:0] expected;
  logic [WORD_W-1:0] processed;
  logic csw_valid;
  logic len_ok;
  logic [WORD_W-1:0] residue;
  logic [WORD_W-1:0] csw_tag;
  modport src (output cbw_valid, cbw_len, cbw_tag, expected, processed,
               input csw_valid, len_ok, residue, csw_tag);
  modport chk (input cbw_valid, cbw_len, cbw_tag, expected, processed,
               output csw_valid, len_ok, residue, csw_tag);
endinterface
`default_nettype wire

/* hw/spptc_pkg.sv */
`default_nettype none
package spptc_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int CTL_W = 8;
  localparam int PD_W = 25;
  localparam int LEN_W = 5;
  localparam int WORD_W = 32;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic PORT_DIS_RST = 1'h1;
  localparam logic HARD_RST_RST = 1'h0;
  localparam logic [PD_W-1:0] PD_EN_RST = 25'h1ffffff;
  localparam logic BOOTING_RST = 1'h1;
  // ----------------------------------------
  // Command block length limits
  // ----------------------------------------
  localparam logic [LEN_W-1:0] CMD_LEN_MIN = 5'h01;
  localparam logic [LEN_W-1:0] CMD_LEN_MAX = 5'h10;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SPPTC_MODE_MANUAL = 2'h0,
    SPPTC_MODE_SEMI = 2'h1,
    SPPTC_MODE_AUTO = 2'h3
  } spptc_mode_t;
  typedef enum logic [1:0] {
    SPPTC_SEQ_OFF = 2'h0,
    SPPTC_SEQ_RST_HELD = 2'h1,
    SPPTC_SEQ_BUS_ON = 2'h3,
    SPPTC_SEQ_RUN = 2'h2
  } spptc_seq_t;
endpackage
`default_nettype wire

/* hw/spptc_top.sv */
`default_nettype none
module spptc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Firmware control bits
  input wire logic port_disable_wr,
  input wire logic port_disable_bit,
  input wire logic hard_reset_wr,
  input wire logic hard_reset_bit,
  input wire logic pd_wr,
  input wire logic [spptc_pkg::PD_W-1:0] pd_wdata,
  input wire logic boot_done,
  input wire logic fw_low_power_req,
  input wire logic fw_high_power_req,
  input wire logic mode_wr,
  input wire spptc_pkg::spptc_mode_t mode_wdata,
  // Upstream supply sense pin
  input wire logic vbus_pin,
  // Core side of the storage bus
  input wire logic core_data_oe,
  input wire logic [spptc_pkg::DATA_W-1:0] core_data_out,
  input wire logic core_ctl_oe,
  input wire logic [spptc_pkg::CTL_W-1:0] core_ctl_out,
  // Storage bus pins
  output logic data_oe,
  output logic [spptc_pkg::DATA_W-1:0] data_out,
  output logic ctl_oe,
  output logic [spptc_pkg::CTL_W-1:0] ctl_out,
  output logic drive_reset_pin_o,
  output logic drive_reset_pin_oe,
  output logic [spptc_pkg::PD_W-1:0] pd_en,
  // Power grant pins, open drain
  output logic low_power_grant_pin_o,
  output logic low_power_grant_pin_oe,
  output logic high_power_grant_pin_o,
  output logic high_power_grant_pin_oe,
  // Status
  output logic vbus_seen,
  output var spptc_pkg::spptc_seq_t seq_state,
  output var spptc_pkg::spptc_mode_t xfer_mode,
  output logic hw_cmd_stage,
  output logic hw_data_stage,
  // Command and status wrapper fields
  input wire logic cbw_valid,
  input wire logic [spptc_pkg::LEN_W-1:0] cbw_len,
  input wire logic [spptc_pkg::WORD_W-1:0] cbw_tag,
  input wire logic [spptc_pkg::WORD_W-1:0] expected_bytes,
  input wire logic [spptc_pkg::WORD_W-1:0] processed_bytes,
  output logic csw_valid,
  output logic cbw_len_ok,
  output logic [spptc_pkg::WORD_W-1:0] csw_residue,
  output logic [spptc_pkg::WORD_W-1:0] csw_tag
);
  import spptc_pkg::*;

  typedef struct packed {
    logic port_dis;
    logic hard_rst;
    logic [PD_W-1:0] pd;
    logic booting;
    logic [2:0] vbus_sync;
    logic vbus;
    logic lp_boot;
    logic lp_oe;
    logic hp_oe;
    logic data_oe;
    logic [DATA_W-1:0] data_out;
    logic ctl_oe;
    logic [CTL_W-1:0] ctl_out;
    logic rst_o;
    logic rst_oe;
    spptc_mode_t mode;
    spptc_seq_t seq;
  } spptc_state_t;

  spptc_state_t s;
  spptc_state_t next_s;

  // ----------------------------------------
  // Control and pin logic
  // ----------------------------------------
  always_comb begin
    next_s = s;
    if (port_disable_wr) begin
      next_s.port_dis = port_disable_bit;
    end
    if (hard_reset_wr) begin
      next_s.hard_rst = hard_reset_bit;
    end
    if (pd_wr) begin
      next_s.pd = pd_wdata;
    end
    if (mode_wr) begin
      next_s.mode = mode_wdata;
    end
    if (boot_done) begin
      next_s.booting = 1'h0;
    end
    // Pin sample: only the agreeing second and third stages count
    next_s.vbus_sync = {s.vbus_sync[1:0], vbus_pin};
    if (s.vbus_sync[2] == s.vbus_sync[1]) begin
      next_s.vbus = s.vbus_sync[2];
    end
    if (s.booting && s.vbus) begin
      next_s.lp_boot = 1'h1;
    end
    // Open drain: output level is always low, only the enable moves
    next_s.lp_oe = next_s.lp_boot | fw_low_power_req;
    next_s.hp_oe = fw_high_power_req;
    // Enables follow the new disable value, so the override lands on the write edge
    next_s.data_oe = core_data_oe & ~next_s.port_dis;
    next_s.ctl_oe = core_ctl_oe & ~next_s.port_dis;
    next_s.data_out = core_data_out;
    next_s.ctl_out = core_ctl_out;
    next_s.rst_o = ~next_s.hard_rst;
    next_s.rst_oe = ~next_s.port_dis;
    // Tracks how far firmware has walked the drive power-up order
    case (s.seq)
      SPPTC_SEQ_OFF: begin
        if (next_s.hard_rst) begin
          next_s.seq = SPPTC_SEQ_RST_HELD;
        end
      end
      SPPTC_SEQ_RST_HELD: begin
        if (!next_s.hard_rst) begin
          next_s.seq = SPPTC_SEQ_OFF;
        end else if (!next_s.port_dis) begin
          next_s.seq = SPPTC_SEQ_BUS_ON;
        end
      end
      SPPTC_SEQ_BUS_ON: begin
        if (next_s.port_dis) begin
          next_s.seq = SPPTC_SEQ_OFF;
        end else if (!next_s.hard_rst) begin
          next_s.seq = SPPTC_SEQ_RUN;
        end
      end
      SPPTC_SEQ_RUN: begin
        if (next_s.port_dis) begin
          next_s.seq = SPPTC_SEQ_OFF;
        end
      end
      default: begin
        next_s.seq = SPPTC_SEQ_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.port_dis <= PORT_DIS_RST;
      s.hard_rst <= HARD_RST_RST;
      s.pd <= PD_EN_RST;
      s.booting <= BOOTING_RST;
      s.rst_o <= 1'h1;
      s.mode <= SPPTC_MODE_MANUAL;
      s.seq <= SPPTC_SEQ_OFF;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign data_oe = s.data_oe;
  assign data_out = s.data_out;
  assign ctl_oe = s.ctl_oe;
  assign ctl_out = s.ctl_out;
  assign drive_reset_pin_o = s.rst_o;
  assign drive_reset_pin_oe = s.rst_oe;
  assign pd_en = s.pd;
  assign low_power_grant_pin_o = 1'h0;
  assign low_power_grant_pin_oe = s.lp_oe;
  assign high_power_grant_pin_o = 1'h0;
  assign high_power_grant_pin_oe = s.hp_oe;
  assign vbus_seen = s.vbus;
  assign seq_state = s.seq;
  assign xfer_mode = s.mode;
  // Hardware never runs the status stage; firmware reads the wrapper fields
  assign hw_cmd_stage = s.mode[1];
  assign hw_data_stage = s.mode[0];

  // ----------------------------------------
  // Wrapper field check
  // ----------------------------------------
  spptc_cmd_if cmd ();
  assign cmd.cbw_valid = cbw_valid;
  assign cmd.cbw_len = cbw_len;
  assign cmd.cbw_tag = cbw_tag;
  assign cmd.expected = expected_bytes;
  assign cmd.processed = processed_bytes;
  assign csw_valid = cmd.csw_valid;
  assign cbw_len_ok = cmd.len_ok;
  assign csw_residue = cmd.residue;
  assign csw_tag = cmd.csw_tag;

  spptc_cmd_check u_check (
    .clk(clk),
    .resetn(resetn),
    .cmd(cmd.chk)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence dis_written;
    port_disable_wr && port_disable_bit;
  endsequence
  sequence bus_quiet;
    !data_oe && !ctl_oe && !drive_reset_pin_oe;
  endsequence

  a_disable_floats: assert property (dis_written |=> bus_quiet)
    else $error("bus driven after disable write");
  a_disable_holds: assert property (s.port_dis |-> bus_quiet)
    else $error("bus driven while disabled");
  a_enable_follows: assert property (port_disable_wr && !port_disable_bit && core_data_oe |=> data_oe)
    else $error("bus not re-enabled");
  a_hard_reset_low: assert property (s.hard_rst && !s.port_dis |-> drive_reset_pin_oe && !drive_reset_pin_o)
    else $error("drive reset not low");
  a_hard_reset_off: assert property (hard_reset_wr && !hard_reset_bit |=> drive_reset_pin_o)
    else $error("drive reset not released");
  a_pulldown_stable: assert property (!pd_wr |=> pd_en == $past(pd_en))
    else $error("pulldowns changed without write");
  a_low_power_boot: assert property (s.booting && s.vbus |=> ##1 low_power_grant_pin_oe)
    else $error("low power grant not driven");
  a_low_power_idle: assert property (!s.lp_boot && !fw_low_power_req && !(s.booting && s.vbus)
      |=> !low_power_grant_pin_oe)
    else $error("low power grant driven unasked");
  a_grant_open_drain: assert property (!low_power_grant_pin_o && !high_power_grant_pin_o)
    else $error("grant pin driven high");
  a_seq_order: assert property (s.seq == SPPTC_SEQ_BUS_ON |-> s.hard_rst && !s.port_dis)
    else $error("sequence state inconsistent");
endmodule
`default_nettype wire

/* sim/spptc_drive_model.sv */
`default_nettype none
module spptc_drive_model (
  // Clock
  input wire logic clk,
  // Pins from the bridge
  input wire logic data_oe,
  input wire logic [spptc_pkg::DATA_W-1:0] data_out,
  input wire logic [spptc_pkg::PD_W-1:0] pd_en,
  input wire logic rst_o,
  input wire logic rst_oe,
  // Levels seen by the drive
  output logic [spptc_pkg::DATA_W-1:0] data_seen,
  output logic rst_seen
);
  import spptc_pkg::*;
  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  // The drive never drives the bus here; a line with no driver and no
  // pulldown shows the inverse of its last level, so a stale value never passes
  logic [DATA_W-1:0] last;
  logic last_rst;
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      data_seen[i] = data_oe ? data_out[i] : (pd_en[i] ? 1'h0 : ~last[i]);
    end
    rst_seen = rst_oe ? rst_o : (pd_en[24] ? 1'h0 : ~last_rst);
  end
  always_ff @(posedge clk) begin
    last <= data_seen;
    last_rst <= rst_seen;
  end
endmodule
`default_nettype wire

/* sim/spptc_top_tb_top.sv */
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module spptc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spptc_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 0, resetn = 0;
  logic port_disable_wr = 0, port_disable_bit = 0, hard_reset_wr = 0, hard_reset_bit = 0;
  logic pd_wr = 0, boot_done = 0, fw_low_power_req = 0, fw_high_power_req = 0, mode_wr = 0;
  logic [PD_W-1:0] pd_wdata = '0;
  spptc_mode_t mode_wdata = SPPTC_MODE_MANUAL;
  logic vbus_pin = 0, core_data_oe = 0, core_ctl_oe = 0, cbw_valid = 0;
  logic [DATA_W-1:0] core_data_out = '0;
  logic [CTL_W-1:0] core_ctl_out = '0;
  logic [LEN_W-1:0] cbw_len = '0;
  logic [WORD_W-1:0] cbw_tag = '0, expected_bytes = '0, processed_bytes = '0;
  logic data_oe, ctl_oe, rst_o, rst_oe, lp_o, lp_oe, hp_o, hp_oe, vbus_seen;
  logic hw_cmd_stage, hw_data_stage, csw_valid, cbw_len_ok, rst_seen;
  logic [DATA_W-1:0] data_out, data_seen;
  logic [CTL_W-1:0] ctl_out;
  logic [PD_W-1:0] pd_en;
  logic [WORD_W-1:0] csw_residue, csw_tag;
  spptc_seq_t seq_state;
  spptc_mode_t xfer_mode;
  int fail_count = 0, n_checks = 0, cyc = 0;
  always #10 clk = ~clk;
  spptc_top u_dut (.clk(clk), .resetn(resetn), .port_disable_wr(port_disable_wr),
    .port_disable_bit(port_disable_bit), .hard_reset_wr(hard_reset_wr), .hard_reset_bit(hard_reset_bit),
    .pd_wr(pd_wr), .pd_wdata(pd_wdata), .boot_done(boot_done), .fw_low_power_req(fw_low_power_req),
    .fw_high_power_req(fw_high_power_req), .mode_wr(mode_wr), .mode_wdata(mode_wdata), .vbus_pin(vbus_pin),
    .core_data_oe(core_data_oe), .core_data_out(core_data_out), .core_ctl_oe(core_ctl_oe),
    .core_ctl_out(core_ctl_out), .data_oe(data_oe), .data_out(data_out), .ctl_oe(ctl_oe), .ctl_out(ctl_out),
    .drive_reset_pin_o(rst_o), .drive_reset_pin_oe(rst_oe), .pd_en(pd_en), .low_power_grant_pin_o(lp_o),
    .low_power_grant_pin_oe(lp_oe), .high_power_grant_pin_o(hp_o), .high_power_grant_pin_oe(hp_oe),
    .vbus_seen(vbus_seen), .seq_state(seq_state), .xfer_mode(xfer_mode), .hw_cmd_stage(hw_cmd_stage),
    .hw_data_stage(hw_data_stage), .cbw_valid(cbw_valid), .cbw_len(cbw_len), .cbw_tag(cbw_tag),
    .expected_bytes(expected_bytes), .processed_bytes(processed_bytes), .csw_valid(csw_valid),
    .cbw_len_ok(cbw_len_ok), .csw_residue(csw_residue), .csw_tag(csw_tag));
  spptc_drive_model u_drive (.clk(clk), .data_oe(data_oe), .data_out(data_out), .pd_en(pd_en),
    .rst_o(rst_o), .rst_oe(rst_oe), .data_seen(data_seen), .rst_seen(rst_seen));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    resetn <= 0;
    repeat (4) @(posedge clk);
    resetn <= 1;
    #1;
  endtask
  // Pulse one write strobe for a single edge; kinds: 0 disable, 1 hard reset, 2 pulldowns, 3 mode, 4 boot end,
  // 5 wrapper
  task automatic wr(input int k, input logic [PD_W-1:0] d);
    @(posedge clk);
    case (k)
      0: begin
        port_disable_wr <= 1;
        port_disable_bit <= d[0];
      end
      1: begin
        hard_reset_wr <= 1;
        hard_reset_bit <= d[0];
      end
      2: begin
        pd_wr <= 1;
        pd_wdata <= d;
      end
      3: begin
        mode_wr <= 1;
        mode_wdata <= spptc_mode_t'(d[1:0]);
      end
      4: boot_done <= 1;
      default: cbw_valid <= 1;
    endcase
    @(posedge clk);
    {port_disable_wr, hard_reset_wr, pd_wr, mode_wr, boot_done, cbw_valid} <= '0;
    #1;
  endtask
  // ----------------------------------------
  // Timeout
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      summarize();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    do_reset();
    `CHK("data_oe", 1'h0, data_oe)
    `CHK("ctl_oe", 1'h0, ctl_oe)
    `CHK("pd_en", 25'h1ffffff, pd_en)
    `CHK("data_seen", 16'h0000, data_seen)
    `CHK("rst_oe", 1'h0, rst_oe)
    `CHK("rst_seen", 1'h0, rst_seen)
    `CHK("grant_oe", 2'h0, {lp_oe, hp_oe})
    core_data_oe <= 1;
    core_data_out <= 16'h5a5a;
    core_ctl_oe <= 1;
    core_ctl_out <= 8'h3c;
    wr(1, 25'h1);
    `CHK("rst_o", 1'h0, rst_o)
    `CHK("rst_oe held", 1'h0, rst_oe)
    `CHK("seq", SPPTC_SEQ_RST_HELD, seq_state)
    wr(0, 25'h0);
    `CHK("bus on", 2'h3, {data_oe, ctl_oe})
    `CHK("bus data", 16'h5a5a, data_seen)
    `CHK("ctl_out", 8'h3c, ctl_out)
    `CHK("rst pin low", 2'h2, {rst_oe, rst_seen})
    `CHK("seq", SPPTC_SEQ_BUS_ON, seq_state)
    wr(1, 25'h0);
    `CHK("rst pin high", 1'h1, rst_seen)
    `CHK("seq", SPPTC_SEQ_RUN, seq_state)
    wr(0, 25'h1);
    `CHK("bus off", 3'h0, {data_oe, ctl_oe, rst_oe})
    `CHK("seq", SPPTC_SEQ_OFF, seq_state)
    wr(2, 25'h0aaaaaa);
    `CHK("pd_en", 25'h0aaaaaa, pd_en)
    for (int m = 0; m < 4; m++) begin
      if (m != 2) begin
        wr(3, 25'(m));
        `CHK("mode", 2'(m), xfer_mode)
        `CHK("stages", 2'(m), {hw_cmd_stage, hw_data_stage})
      end
    end
    for (int i = 0; i < 4; i++) begin
      cbw_len <= (i == 0) ? 5'h00 : (i == 1) ? 5'h01 : (i == 2) ? 5'h10 : 5'h11;
      cbw_tag <= 32'hc0de0000 + 32'(i);
      expected_bytes <= 32'h00000200;
      processed_bytes <= 32'h00000100 * 32'(i);
      wr(5, 25'h0);
      `CHK("csw_valid", 1'h1, csw_valid)
      `CHK("len_ok", (i == 1 || i == 2), cbw_len_ok)
      `CHK("residue", 32'h00000200 - 32'h00000100 * 32'(i), csw_residue)
      `CHK("tag", 32'hc0de0000 + 32'(i), csw_tag)
    end
    @(posedge clk);
    #1;
    `CHK("csw pulse", 1'h0, csw_valid)
    vbus_pin <= 1;
    repeat (8) @(posedge clk);
    #1;
    `CHK("vbus_seen", 1'h1, vbus_seen)
    `CHK("lp_oe", 2'h1, {lp_o, lp_oe})
    wr(4, 25'h0);
    `CHK("lp_oe kept", 1'h1, lp_oe)
    vbus_pin <= 0;
    do_reset();
    wr(4, 25'h0);
    vbus_pin <= 1;
    repeat (8) @(posedge clk);
    #1;
    `CHK("lp_oe idle", 1'h0, lp_oe)
    fw_low_power_req <= 1;
    fw_high_power_req <= 1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("grants", 4'h5, {lp_o, lp_oe, hp_o, hp_oe})
    summarize();
  end
endmodule
`default_nettype wire
